// ---- hdl/ersq_consts.vh ----
// Purpose: constants of the exposure/readout shutter sequencer
// Assumes: word-wide register port, 12-bit register addresses
// Notes: locations pack line in [11:0] and pixel in [25:13]
`ifndef ERSQ_CONSTS_VH
`define ERSQ_CONSTS_VH

// Register addresses
`define ERSQ_A_SYNC_DIR 12'h012
`define ERSQ_A_MODE 12'h060
`define ERSQ_A_TRIGGER 12'h061
`define ERSQ_A_READOUT_NUM 12'h062
`define ERSQ_A_EXPOSE_NUM 12'h063
`define ERSQ_A_SUBSTRATE_BIAS_OUT_MODE 12'h069
`define ERSQ_A_SUBSTRATE_BIAS_OUT_ON 12'h06a
`define ERSQ_A_SHUTTER0_ON_LOCATION 12'h06d
`define ERSQ_A_SHUTTER0_OFF_LOCATION 12'h071
`define ERSQ_A_SHUTTER_SIGNAL_1_CTRL 12'h072
`define ERSQ_A_SHUTTER1_MANUAL_ON 12'h074
`define ERSQ_A_SHUTTER1_OFF_FIELD 12'h075
`define ERSQ_A_SHUTTER_SIGNAL_1_OFF 12'h076
`define ERSQ_A_STATUS 12'h07f
`define ERSQ_A_FG_CTRL 12'h0f1

// Trigger register bits
`define ERSQ_TRG_STROBE 0
`define ERSQ_TRG_MECH_SHUTTER_OUT 1
`define ERSQ_TRG_SUBSTRATE_BIAS_OUT 4
`define ERSQ_TRG_START 7

// Shutter-1 control bits
`define ERSQ_S1_MAN_ON 0
`define ERSQ_S1_POL 1
`define ERSQ_S1_MAN_EN 2

// Substrate-bias mode bits
`define ERSQ_VS_MODE 0
`define ERSQ_VS_KEEP 1

// Field-pulse control
`define ERSQ_FG_EN 3

// Location field layout
`define ERSQ_LN_HI 11
`define ERSQ_PX_LO 13
`define ERSQ_PX_HI 25

// Reset values
`define ERSQ_RST_SYNC_DIR 1'h0
`define ERSQ_RST_MODE 3'h5
`define ERSQ_RST_COUNT 3'h1

`endif

// ---- hdl/ersq_pin_sync.v ----
// Purpose: three-flop synchroniser for the sync pins
// Assumes: pins are asynchronous to core_clk
// Notes: a level counts once stages two and three agree
module ersq_pin_sync (
	input wire core_clk,
	input wire sys_rst,
	input wire clkEn,
	input wire [2:0] pinIn,
	output reg [2:0] levelOut,
	output reg [2:0] fallOut
);
	reg [2:0] st1Reg; // First stage, read only by st2Reg
	reg [2:0] st2Reg; // Second stage
	reg [2:0] st3Reg; // Third stage
	integer i;

	// Shift chain, filtered level and falling-edge pulse
	always @(posedge core_clk) begin
		if (sys_rst) begin
			st1Reg <= 3'h7;
			st2Reg <= 3'h7;
			st3Reg <= 3'h7;
			levelOut <= 3'h7;
			fallOut <= 3'h0;
		end else if (clkEn) begin
			st1Reg <= pinIn;
			st2Reg <= st1Reg;
			st3Reg <= st2Reg;
			for (i = 0; i < 3; i = i + 1) begin
				// Agreeing stages update the level
				if (st2Reg[i] == st3Reg[i]) begin
					levelOut[i] <= st3Reg[i];
					fallOut[i] <= levelOut[i] & ~st3Reg[i];
				end else begin
					fallOut[i] <= 1'b0;
				end
			end
		end
	end
endmodule // ersq_pin_sync

// ---- hdl/ersq_seq.v ----
// Purpose: exposure, readout and shutter sequencer of a CCD timing core
// Assumes: VD/HD and sync pin arrive asynchronously, core_clk 50 MHz
// Notes: all writes land in shadows and apply at the VD falling edge
// Function
// - Suppress substrate clock for readout field count
// - Exposure suppresses substrate clock and sensor gate
// - Trigger write arms signals and starts operation
// - Readout follows exposure without host write
// - Writes apply at next VD/HD falling edge; the code applies them at the VD fall only
// - Bias mode zero: bias on at line
// - Strobe on/off at shutter-0 locations
// - Shutter off at field/line/pixel; on at on line/pixel in field zero if off
// - Each readout field starts at VD fall
// - Manual enable plus on forces shutter on
// - Gate resumes at readout start; after readout: clock resume, bias off
// - Mode write sets next field sequence length
// - Gated pulse uses shutter-1 line/pixel only
// - Three-bit field selects gated pulse field
// - Gated pulse output only while enabled
// - Direction bit: pin output or sync input
// - Control bit 1 gives pulse start polarity
// - First toggle at on line and pixel
// - Second toggle at off line and pixel
// - Keep-on bit holds bias after readout
`include "ersq_consts.vh"
module ersq_seq (
	input wire core_clk,
	input wire sys_rst,
	input wire clkEn,
	input wire [11:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	input wire vdPinIn,
	input wire hdPinIn,
	input wire syncPinIn,
	output reg strobeOut,
	output reg mechShutterOut,
	output reg substrateBiasOut,
	output reg substrateClockEn,
	output reg sensorGateEn,
	output reg syncPinOut,
	output reg syncPinOe
);
	// Sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_EXPOSE = 2'h1;
	localparam ST_READOUT = 2'h2;

	wire [2:0] pinLevel; // Filtered pin levels
	wire [2:0] pinFall; // Falling-edge pulses
	wire vdFall; // Field boundary
	wire hdFall; // Line boundary

	// Shadow copies written by software
	reg syncDirSh;
	reg [2:0] modeSh;
	reg [7:0] trigSh;
	reg trigPendSh; // Trigger written since last update
	reg [2:0] readNumSh;
	reg [2:0] expNumSh;
	reg [1:0] vsModeSh;
	reg [11:0] vsOnSh;
	reg [25:0] s0OnSh;
	reg [25:0] s0OffSh;
	reg [2:0] s1CtrlSh;
	reg s1CtrlPendSh; // Control written since last update
	reg [25:0] s1OnSh;
	reg [11:0] s1OffFdSh;
	reg [25:0] s1OffSh;
	reg [3:0] fgCtrlSh;

	// Active copies used by the logic
	reg syncDir_reg;
	reg [2:0] mode_reg;
	reg [2:0] readNum_reg;
	reg [2:0] expNum_reg;
	reg [1:0] vsMode_reg;
	reg [11:0] vsOn_reg;
	reg [25:0] s0On_reg;
	reg [25:0] s0Off_reg;
	reg [2:0] s1Ctrl_reg;
	reg [25:0] s1On_reg;
	reg [11:0] s1OffFd_reg;
	reg [25:0] s1Off_reg;
	reg [3:0] fgCtrl_reg;

	// Timing and sequence state
	reg [12:0] pixCnt_reg; // Pixel within line
	reg [11:0] lineCnt_reg; // Line within field
	reg [11:0] opField_reg; // Field since operation start
	reg [2:0] modeField_reg; // Field within mode sequence
	reg [2:0] fieldsLeft_reg; // Fields left in this phase
	reg [1:0] state_reg;
	reg armStrobe_reg;
	reg armMshut_reg;
	reg armVsub_reg;
	reg fgPulse_reg; // Gated pulse level

	// Location compare against current counters
	function locHit;
		input [25:0] loc;
		input [11:0] ln;
		input [12:0] px;
		begin
			locHit = (loc[`ERSQ_LN_HI:0] == ln) &&
				(loc[`ERSQ_PX_HI:`ERSQ_PX_LO] == px);
		end
	endfunction

	// Pin synchroniser: bit0 VD, bit1 HD, bit2 sync input
	ersq_pin_sync u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.pinIn({syncPinIn, hdPinIn, vdPinIn}),
		.levelOut(pinLevel),
		.fallOut(pinFall)
	);
	assign vdFall = pinFall[0];
	assign hdFall = pinFall[1];

	// Register port: shadow writes and read-back
	always @(posedge core_clk) begin
		if (sys_rst) begin
			syncDirSh <= `ERSQ_RST_SYNC_DIR;
			modeSh <= `ERSQ_RST_MODE;
			trigSh <= 8'h00;
			trigPendSh <= 1'b0;
			readNumSh <= `ERSQ_RST_COUNT;
			expNumSh <= `ERSQ_RST_COUNT;
			vsModeSh <= 2'h0;
			vsOnSh <= 12'h000;
			s0OnSh <= 26'h0000000;
			s0OffSh <= 26'h0000000;
			s1CtrlSh <= 3'h0;
			s1CtrlPendSh <= 1'b0;
			s1OnSh <= 26'h0000000;
			s1OffFdSh <= 12'h000;
			s1OffSh <= 26'h0000000;
			fgCtrlSh <= 4'h0;
			regRdData <= 32'h00000000;
		end else if (clkEn) begin
			// Pending flags drop at the update edge; a write wins
			if (vdFall) begin
				trigPendSh <= 1'b0;
				s1CtrlPendSh <= 1'b0;
			end
			if (regWr) begin
				case (regAddr)
					`ERSQ_A_SYNC_DIR: syncDirSh <= regWrData[0];
					`ERSQ_A_MODE: modeSh <= regWrData[2:0];
					`ERSQ_A_TRIGGER: begin
						trigSh <= regWrData[7:0];
						trigPendSh <= 1'b1;
					end
					`ERSQ_A_READOUT_NUM: readNumSh <= regWrData[2:0];
					`ERSQ_A_EXPOSE_NUM: expNumSh <= regWrData[2:0];
					`ERSQ_A_SUBSTRATE_BIAS_OUT_MODE: vsModeSh <= regWrData[1:0];
					`ERSQ_A_SUBSTRATE_BIAS_OUT_ON: vsOnSh <= regWrData[11:0];
					`ERSQ_A_SHUTTER0_ON_LOCATION: s0OnSh <= regWrData[25:0];
					`ERSQ_A_SHUTTER0_OFF_LOCATION: s0OffSh <= regWrData[25:0];
					`ERSQ_A_SHUTTER_SIGNAL_1_CTRL: begin
						s1CtrlSh <= regWrData[2:0];
						s1CtrlPendSh <= 1'b1;
					end
					`ERSQ_A_SHUTTER1_MANUAL_ON: s1OnSh <= regWrData[25:0];
					`ERSQ_A_SHUTTER1_OFF_FIELD: s1OffFdSh <= regWrData[11:0];
					`ERSQ_A_SHUTTER_SIGNAL_1_OFF: s1OffSh <= regWrData[25:0];
					`ERSQ_A_FG_CTRL: fgCtrlSh <= regWrData[3:0];
					default: begin
						// Unmapped writes are dropped
					end
				endcase
			end
			// Read data one cycle after the strobe, else zero
			regRdData <= 32'h00000000;
			if (regRd) begin
				case (regAddr)
					`ERSQ_A_SYNC_DIR: regRdData <= {31'h0, syncDirSh};
					`ERSQ_A_MODE: regRdData <= {29'h0, modeSh};
					`ERSQ_A_TRIGGER: regRdData <= {24'h0, trigSh};
					`ERSQ_A_READOUT_NUM: regRdData <= {29'h0, readNumSh};
					`ERSQ_A_EXPOSE_NUM: regRdData <= {29'h0, expNumSh};
					`ERSQ_A_SUBSTRATE_BIAS_OUT_MODE: regRdData <= {30'h0, vsModeSh};
					`ERSQ_A_SUBSTRATE_BIAS_OUT_ON: regRdData <= {20'h0, vsOnSh};
					`ERSQ_A_SHUTTER0_ON_LOCATION: regRdData <= {6'h0, s0OnSh};
					`ERSQ_A_SHUTTER0_OFF_LOCATION: regRdData <= {6'h0, s0OffSh};
					`ERSQ_A_SHUTTER_SIGNAL_1_CTRL: regRdData <= {29'h0, s1CtrlSh};
					`ERSQ_A_SHUTTER1_MANUAL_ON: regRdData <= {6'h0, s1OnSh};
					`ERSQ_A_SHUTTER1_OFF_FIELD:
						regRdData <= {20'h0, s1OffFdSh};
					`ERSQ_A_SHUTTER_SIGNAL_1_OFF: regRdData <= {6'h0, s1OffSh};
					`ERSQ_A_FG_CTRL: regRdData <= {28'h0, fgCtrlSh};
					`ERSQ_A_STATUS: regRdData <= {14'h0,
						pinLevel[2], 4'h0, trigPendSh, modeField_reg,
						fieldsLeft_reg, state_reg, fgPulse_reg,
						substrateBiasOut, mechShutterOut, strobeOut};
					default: regRdData <= 32'h00000000;
				endcase
			end
		end
	end

	// Pixel and line counters from HD and VD falls
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pixCnt_reg <= 13'h0000;
			lineCnt_reg <= 12'h000;
		end else if (clkEn) begin
			if (hdFall) begin
				pixCnt_reg <= 13'h0000;
			end else begin
				pixCnt_reg <= pixCnt_reg + 13'h0001;
			end
			if (vdFall) begin
				lineCnt_reg <= 12'h000;
			end else if (hdFall) begin
				lineCnt_reg <= lineCnt_reg + 12'h001;
			end
		end
	end

	// Copy shadows to active registers at the field edge
	always @(posedge core_clk) begin
		if (sys_rst) begin
			syncDir_reg <= `ERSQ_RST_SYNC_DIR;
			mode_reg <= `ERSQ_RST_MODE;
			readNum_reg <= `ERSQ_RST_COUNT;
			expNum_reg <= `ERSQ_RST_COUNT;
			vsMode_reg <= 2'h0;
			vsOn_reg <= 12'h000;
			s0On_reg <= 26'h0000000;
			s0Off_reg <= 26'h0000000;
			s1Ctrl_reg <= 3'h0;
			s1On_reg <= 26'h0000000;
			s1OffFd_reg <= 12'h000;
			s1Off_reg <= 26'h0000000;
			fgCtrl_reg <= 4'h0;
		end else if (clkEn && vdFall) begin
			syncDir_reg <= syncDirSh;
			mode_reg <= modeSh;
			readNum_reg <= readNumSh;
			expNum_reg <= expNumSh;
			vsMode_reg <= vsModeSh;
			vsOn_reg <= vsOnSh;
			s0On_reg <= s0OnSh;
			s0Off_reg <= s0OffSh;
			s1Ctrl_reg <= s1CtrlSh;
			s1On_reg <= s1OnSh;
			s1OffFd_reg <= s1OffFdSh;
			s1Off_reg <= s1OffSh;
			fgCtrl_reg <= fgCtrlSh;
		end
	end

	// Exposure and readout sequencer with shutter outputs
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			fieldsLeft_reg <= 3'h0;
			opField_reg <= 12'h000;
			armStrobe_reg <= 1'b0;
			armMshut_reg <= 1'b0;
			armVsub_reg <= 1'b0;
			strobeOut <= 1'b0;
			mechShutterOut <= 1'b0;
			substrateBiasOut <= 1'b0;
			substrateClockEn <= 1'b1;
			sensorGateEn <= 1'b1;
		end else if (clkEn) begin
			if (vdFall) begin
				opField_reg <= opField_reg + 12'h001;
				case (state_reg)
					ST_IDLE: begin
						// Applied trigger arms and starts
						if (trigPendSh && trigSh[`ERSQ_TRG_START]) begin
							state_reg <= ST_EXPOSE;
							fieldsLeft_reg <= expNumSh;
							opField_reg <= 12'h000;
							armStrobe_reg <= trigSh[`ERSQ_TRG_STROBE];
							// Manual control must be clear to arm
							armMshut_reg <= trigSh[`ERSQ_TRG_MECH_SHUTTER_OUT] &
								~s1CtrlSh[`ERSQ_S1_MAN_EN];
							armVsub_reg <= trigSh[`ERSQ_TRG_SUBSTRATE_BIAS_OUT];
							if (trigSh[`ERSQ_TRG_SUBSTRATE_BIAS_OUT] &&
								vsModeSh[`ERSQ_VS_MODE]) begin
								substrateBiasOut <= 1'b1;
							end
						end
					end
					ST_EXPOSE: begin
						if (fieldsLeft_reg <= 3'h1) begin
							state_reg <= ST_READOUT;
							fieldsLeft_reg <= readNum_reg;
							armStrobe_reg <= 1'b0;
						end else begin
							fieldsLeft_reg <= fieldsLeft_reg - 3'h1;
						end
					end
					ST_READOUT: begin
						// Each VD fall opens the next readout field
						if (fieldsLeft_reg <= 3'h1) begin
							state_reg <= ST_IDLE;
							fieldsLeft_reg <= 3'h0;
							armMshut_reg <= 1'b0;
							armVsub_reg <= 1'b0;
							if (!vsMode_reg[`ERSQ_VS_KEEP]) begin
								substrateBiasOut <= 1'b0;
							end
						end else begin
							fieldsLeft_reg <= fieldsLeft_reg - 3'h1;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end else if (state_reg == ST_EXPOSE) begin
				// Bias on at the programmed line in mode zero
				if (armVsub_reg && !vsMode_reg[`ERSQ_VS_MODE] &&
					lineCnt_reg == vsOn_reg) begin
					substrateBiasOut <= 1'b1;
				end
				// Strobe window
				if (armStrobe_reg &&
					locHit(s0On_reg, lineCnt_reg, pixCnt_reg)) begin
					strobeOut <= 1'b1;
				end else if (locHit(s0Off_reg, lineCnt_reg,
					pixCnt_reg)) begin
					strobeOut <= 1'b0;
				end
			end
			// Mechanical shutter: auto off, on only when not on
			if (armMshut_reg && state_reg != ST_IDLE && !vdFall) begin
				if (opField_reg == s1OffFd_reg &&
					locHit(s1Off_reg, lineCnt_reg, pixCnt_reg)) begin
					mechShutterOut <= 1'b0;
					armMshut_reg <= 1'b0;
				end else if (!mechShutterOut && opField_reg == 12'h000 &&
					locHit(s1On_reg, lineCnt_reg, pixCnt_reg)) begin
					mechShutterOut <= 1'b1;
				end
			end
			// Manual force applied with the control update
			if (vdFall && s1CtrlPendSh &&
				s1CtrlSh[`ERSQ_S1_MAN_EN]) begin
				mechShutterOut <= s1CtrlSh[`ERSQ_S1_MAN_ON];
			end
			// Suppression of substrate clock and sensor gate
			substrateClockEn <= (state_reg == ST_IDLE);
			sensorGateEn <= (state_reg != ST_EXPOSE);
		end
	end

	// Mode field counter and field-gated pulse
	always @(posedge core_clk) begin
		if (sys_rst) begin
			modeField_reg <= 3'h0;
			fgPulse_reg <= 1'b0;
			syncPinOut <= 1'b0;
			syncPinOe <= 1'b1;
		end else if (clkEn) begin
			if (vdFall) begin
				// Sequence length follows the applied mode write
				if (modeField_reg + 3'h1 >= mode_reg) begin
					modeField_reg <= 3'h0;
				end else begin
					modeField_reg <= modeField_reg + 3'h1;
				end
				// Polarity being applied at this edge, not the old one
				fgPulse_reg <= s1CtrlSh[`ERSQ_S1_POL];
			end else if (modeField_reg == fgCtrl_reg[2:0]) begin
				// Toggles only in the selected field, no field regs
				if (locHit(s1On_reg, lineCnt_reg, pixCnt_reg)) begin
					fgPulse_reg <= ~s1Ctrl_reg[`ERSQ_S1_POL];
				end else if (locHit(s1Off_reg, lineCnt_reg,
					pixCnt_reg)) begin
					fgPulse_reg <= s1Ctrl_reg[`ERSQ_S1_POL];
				end
			end
			// Pin drives the pulse only as an enabled output
			syncPinOe <= ~syncDir_reg;
			syncPinOut <= ~syncDir_reg & fgCtrl_reg[`ERSQ_FG_EN] &
				fgPulse_reg;
		end
	end
endmodule // ersq_seq

// ---- verification/ersq_seq_properties.sv ----
// Purpose: port-level properties of the sequencer
// Assumes: VD pin comes from the sync model
// Notes: vdAge counts clocks since the VD pin fell
module ersq_seq_properties (
	input wire core_clk,
	input wire sys_rst,
	input wire vdPinIn,
	input wire strobeOut,
	input wire mechShutterOut,
	input wire substrateBiasOut,
	input wire substrateClockEn,
	input wire sensorGateEn,
	input wire syncPinOut,
	input wire syncPinOe
);
	timeunit 1ns;
	timeprecision 1ps;
	reg vdPrev = 1'b1; // Last VD pin level
	reg [4:0] vdAge = 5'h1f; // Saturating age of VD fall
	// Age of the latest VD pin fall
	always @(posedge core_clk) begin
		vdPrev <= vdPinIn;
		if (vdPrev && !vdPinIn)
			vdAge <= 5'h0;
		else if (vdAge != 5'h1f)
			vdAge <= vdAge + 5'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_expose_pair: assert property (
		$fell(substrateClockEn) |-> $fell(sensorGateEn))
		else $error("clock and gate not suppressed together");
	chk_readout_gate: assert property (
		$rose(sensorGateEn) |-> !substrateClockEn)
		else $error("clock running at readout start");
	chk_resume_gate: assert property (
		$rose(substrateClockEn) |-> sensorGateEn && $past(sensorGateEn))
		else $error("clock resumed outside readout end");
	chk_field_at_vd: assert property (
		$changed(sensorGateEn) |-> vdAge < 5'hc)
		else $error("gate changed away from VD fall");
	chk_write_at_vd: assert property (
		$changed(syncPinOe) |-> vdAge < 5'hc)
		else $error("pin direction changed away from VD fall");
	chk_pulse_oe: assert property (
		syncPinOut |-> syncPinOe)
		else $error("pulse high while pin is input");
	chk_strobe_expose: assert property (
		$rose(strobeOut) |-> !sensorGateEn)
		else $error("strobe rose outside exposure");
	chk_bias_in_op: assert property (
		$rose(substrateBiasOut) |-> ##[0:2] !substrateClockEn)
		else $error("bias rose outside operation");
	cover property ($fell(substrateClockEn));
	cover property ($fell(mechShutterOut));
	cover property ($fell(syncPinOut));
endmodule // ersq_seq_properties

// ---- verification/ersq_sync_model.sv ----
// Purpose: sync source and sync pin partner of the sequencer
// Assumes: eight lines of forty clocks per field
// Notes: VD and HD fall together at each field start
module ersq_sync_model (
	input wire core_clk,
	input wire syncPinOe,
	input wire syncPinOut,
	output reg vdPinIn = 1'b1,
	output reg hdPinIn = 1'b1,
	output wire syncPinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [8:0] posCnt = 9'h0; // Clock position in the field
	// Free-running field position and sync levels
	always @(posedge core_clk) begin
		posCnt <= (posCnt == 9'h13f) ? 9'h0 : posCnt + 9'h1;
		hdPinIn <= (posCnt % 9'h28) >= 9'h4;
		vdPinIn <= posCnt >= 9'h28;
	end
	// Device drive wins, else the pull-up holds it high
	assign syncPinIn = syncPinOe ? syncPinOut : 1'b1;
endmodule // ersq_sync_model

// ---- verification/test_exposure_readout_shutter_seq.sv ----
// Purpose: self-checking bench of the sequencer
// Assumes: sync model gives 8 lines of 40 clocks
// Notes: outputs are sampled on the falling clock edge
module test_exposure_readout_shutter_seq;
	timeunit 1ns;
	timeprecision 1ps;
	reg core_clk = 1'b0; // Core clock
	reg sys_rst = 1'b1; // Synchronous reset
	reg [11:0] regAddr = 12'h0; // Register address
	reg [31:0] regWrData = 32'h0; // Write data
	reg regWr = 1'b0; // Write strobe
	reg regRd = 1'b0; // Read strobe
	reg clkEn = 1'b1; // Clock enable
	wire [31:0] regRdData;
	wire vdPinIn, hdPinIn, syncPinIn;
	wire strobeOut, mechShutterOut, substrateBiasOut;
	wire substrateClockEn, sensorGateEn, syncPinOut, syncPinOe;
	integer err_total = 0;
	integer n_checks = 0;
	// Free-running clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	ersq_seq dut_u (.core_clk, .sys_rst, .clkEn, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .vdPinIn, .hdPinIn,
		.syncPinIn, .strobeOut, .mechShutterOut, .substrateBiasOut,
		.substrateClockEn, .sensorGateEn, .syncPinOut, .syncPinOe);
	ersq_sync_model sync_u (.core_clk, .syncPinOe, .syncPinOut,
		.vdPinIn, .hdPinIn, .syncPinIn);
	// Compare and count
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("Error %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// Verdict and end of run
	task final_report;
		begin
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// One-cycle register write
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
			@(posedge core_clk);
			regWr <= 1'b0;
		end
	endtask
	// One-cycle read, data judged in the next cycle
	task rd(input [11:0] a, input [31:0] exp, input string name);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge core_clk);
			regRd <= 1'b0;
			@(negedge core_clk);
			chk(name, regRdData, exp);
		end
	endtask
	// Bounded wait for a VD or HD pin fall
	task edgeWait(input bit useVd);
		reg prev;
		reg cur;
		reg hit;
		integer i;
		begin
			hit = 1'b0;
			prev = useVd ? vdPinIn : hdPinIn;
			for (i = 0; i < 400 && !hit; i = i + 1) begin
				@(negedge core_clk);
				cur = useVd ? vdPinIn : hdPinIn;
				hit = prev && !cur;
				prev = cur;
			end
			if (!hit) begin
				err_total = err_total + 1;
				$display("Error sync fall expected 1 seen 0");
				final_report;
			end
		end
	endtask
	// Skip fields, then lines, then into the line
	task at(input integer fields, input integer ln);
		integer j;
		begin
			for (j = 0; j < fields; j = j + 1)
				edgeWait(1'b1);
			for (j = 0; j < ln; j = j + 1)
				edgeWait(1'b0);
			repeat (20) @(negedge core_clk);
		end
	endtask
	// Held reset
	task resetDut;
		begin
			@(posedge core_clk);
			sys_rst <= 1'b1;
			repeat (20) @(posedge core_clk);
			sys_rst <= 1'b0;
		end
	endtask
	// Reset values, shadow readback, unmapped read
	task scnRegs;
		begin
			rd(12'h012, 32'h0, "direction reset");
			rd(12'h060, 32'h5, "mode reset");
			rd(12'h062, 32'h1, "readout reset");
			rd(12'h063, 32'h1, "expose reset");
			wr(12'h0f1, 32'hd);
			rd(12'h0f1, 32'hd, "pulse control");
			// A write while frozen must not land
			@(posedge core_clk);
			clkEn <= 1'b0;
			wr(12'h0f1, 32'h5);
			clkEn <= 1'b1;
			rd(12'h0f1, 32'hd, "frozen write");
			rd(12'h3ff, 32'h0, "unmapped");
		end
	endtask
	// Exposure then three readout fields
	task scnExpose;
		integer f;
		begin
			at(1, 1);
			wr(12'h062, 32'h3);
			wr(12'h063, 32'h1);
			wr(12'h069, 32'h0);
			wr(12'h06a, 32'h2);
			wr(12'h06d, 32'ha002);
			wr(12'h071, 32'ha004);
			wr(12'h061, 32'h93);
			rd(12'h062, 32'h3, "readout shadow");
			chk("clock before VD", substrateClockEn, 1);
			at(1, 1);
			chk("bias early", substrateBiasOut, 0);
			chk("strobe early", strobeOut, 0);
			at(0, 2);
			chk("expose clock", substrateClockEn, 0);
			chk("expose gate", sensorGateEn, 0);
			chk("bias on", substrateBiasOut, 1);
			chk("strobe on", strobeOut, 1);
			at(0, 2);
			chk("strobe off", strobeOut, 0);
			for (f = 0; f < 3; f = f + 1) begin
				at(1, 1);
				chk("readout clock", substrateClockEn, 0);
				chk("readout gate", sensorGateEn, 1);
			end
			at(1, 1);
			chk("resumed clock", substrateClockEn, 1);
			chk("bias released", substrateBiasOut, 0);
		end
	endtask
	// Bias kept after readout
	task scnKeep;
		begin
			at(1, 1);
			wr(12'h069, 32'h2);
			wr(12'h06a, 32'h1);
			wr(12'h061, 32'h90);
			at(3, 3);
			chk("idle clock", substrateClockEn, 1);
			chk("kept bias", substrateBiasOut, 1);
		end
	endtask
	// Manual shutter, automatic close, manual force
	task scnShutter;
		begin
			at(1, 1);
			wr(12'h072, 32'h5);
			at(1, 1);
			chk("manual on", mechShutterOut, 1);
			wr(12'h072, 32'h0);
			wr(12'h074, 32'ha001);
			wr(12'h075, 32'h1);
			wr(12'h076, 32'ha002);
			at(1, 1);
			wr(12'h061, 32'h82);
			at(1, 3);
			chk("shutter held", mechShutterOut, 1);
			at(1, 3);
			chk("shutter closed", mechShutterOut, 0);
			wr(12'h072, 32'h5);
			at(1, 1);
			chk("forced on", mechShutterOut, 1);
		end
	endtask
	// Field-gated pulse, enable and pin direction
	task scnPulse;
		integer f;
		integer hits;
		begin
			at(1, 1);
			wr(12'h072, 32'h2);
			wr(12'h074, 32'ha002);
			wr(12'h076, 32'ha004);
			wr(12'h075, 32'h7);
			wr(12'h0f1, 32'h8);
			hits = 0;
			for (f = 0; f < 5; f = f + 1) begin
				at(1, 1);
				chk("pulse rest", syncPinOut, 1);
				chk("pin driven", syncPinOe, 1);
				at(0, 2);
				hits = hits + (syncPinOut === 1'b0);
				at(0, 2);
				chk("pulse revert", syncPinOut, 1);
			end
			chk("pulse fields", hits, 1);
			wr(12'h0f1, 32'h0);
			at(1, 3);
			chk("pulse disabled", syncPinOut, 0);
			wr(12'h012, 32'h1);
			wr(12'h0f1, 32'h8);
			at(1, 3);
			chk("pin input", syncPinOe, 0);
			chk("pin pulled up", syncPinIn, 1);
		end
	endtask
	// Main sequence
	initial begin
		resetDut;
		scnRegs;
		scnExpose;
		resetDut;
		scnKeep;
		resetDut;
		scnShutter;
		resetDut;
		scnPulse;
		final_report;
	end
endmodule // test_exposure_readout_shutter_seq
bind ersq_seq ersq_seq_properties chk_u (.core_clk, .sys_rst,
	.vdPinIn, .strobeOut, .mechShutterOut, .substrateBiasOut,
	.substrateClockEn, .sensorGateEn, .syncPinOut, .syncPinOe);
